// >>> src/ssc_pkg.sv
// Shared constants for the single-shot, sleep and checksum command block.
// Assumes a 250 MHz system clock and a 7-bit two-wire bus address.
package ssc_pkg;

    // ----------
    // Command words
    // ----------
    localparam logic [15:0] CMD_MEAS_FULL = 16'h219d;
    localparam logic [15:0] CMD_MEAS_RHT = 16'h2196;
    localparam logic [15:0] CMD_SLEEP = 16'h36e0;
    localparam logic [15:0] CMD_WAKE = 16'h36f6;

    // ----------
    // Checksum properties
    // ----------
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_XOR_OUT = 8'h00;

    // ----------
    // Bus and word framing
    // ----------
    localparam logic [6:0] DEV_ADDR_DEF = 7'h10;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] POS_HI = 2'h0;
    localparam logic [1:0] POS_LO = 2'h1;
    localparam logic [1:0] POS_CRC = 2'h2;
    localparam logic [1:0] LAST_WORD = 2'h2;

    // ----------
    // Timing
    // ----------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CYC_PER_MS = 1000 * CLK_MHZ;
    localparam int unsigned MEAS_FULL_CYC = 5000 * CYC_PER_MS;
    localparam int unsigned MEAS_RHT_CYC = 50 * CYC_PER_MS;
    localparam int unsigned SLEEP_CYC = 1 * CYC_PER_MS;
    localparam int unsigned WAKE_CYC = 20 * CYC_PER_MS;
    localparam int CNT_W = 31;

endpackage

// >>> src/ssc_crc_if.sv
// Carrier between the command engine and its checksum unit.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none

interface ssc_crc_if;
    logic init;
    logic feed;
    logic [7:0] data;
    logic [7:0] crc;

    modport eng (output init, output feed, output data, input crc);
    modport unit (input init, input feed, input data, output crc);
endinterface // ssc_crc_if

`default_nettype wire

// >>> src/ssc_crc8.sv
// Running CRC-8 over the two bytes of one data word.
// Assumes the engine raises init with the first byte of every word.
`timescale 1ns/100ps
`default_nettype none

module ssc_crc8
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Engine side
    ssc_crc_if.unit cif
);

    // ----------
    // Byte step
    // ----------

    // Folds one byte into the checksum, most significant bit first.
    function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                             input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
        begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r ^ CRC_XOR_OUT;
    endfunction

    logic [7:0] crc_q;
    logic [7:0] crc_d;

    // A new word restarts from the seed, so no older byte leaks in.
    always_comb
    begin
        crc_d = crc_q;
        if (cif.feed)
        begin
            crc_d = crc8_step(cif.init ? CRC_INIT : crc_q, cif.data);
        end
    end

    // Registers the checksum.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            crc_q <= CRC_INIT;
        end
        else
        begin
            crc_q <= crc_d;
        end
    end

    assign cif.crc = crc_q;

endmodule // ssc_crc8

`default_nettype wire

// >>> src/ssc_cmd_top.sv
// Two-wire command handler for single-shot measurement and sleep control.
// Assumes scl and sda arrive synchronous to ref_clk and an outside
// measurement engine that answers meas_start with result_valid.
//
// Overview of operation
// - Command 0x219d starts a full measurement; allowed up to 5000 ms.
// - Command 0x2196 starts humidity and temperature only; up to 50 ms.
// - After humidity-and-temperature-only measurement, gas word reads zero.
// - Command 0x36e0 sends device to sleep; host waits at least 1 ms.
// - Command 0x36f6 wakes device into idle; host waits up to 20 ms.
// - The wake-up transfer is not acknowledged; host accepts that.
// - Each 16-bit data word is followed by an 8-bit checksum.
// - Checksum covers exactly the two bytes just before it.
// - Command words carry no checksum byte.
// - CRC-8, polynomial 0x31, seed 0xff, MSB first, no reflection, xor 0.
// - Checksums guard host-written words and device-returned words alike.
`timescale 1ns/100ps
`default_nettype none

module ssc_cmd_top
    import ssc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
    parameter int unsigned MEAS_FULL_CYCLES = MEAS_FULL_CYC,
    parameter int unsigned MEAS_RHT_CYCLES = MEAS_RHT_CYC,
    parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Two-wire bus, open drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output var logic sda_o,
    output var logic sda_oe,
    // Measurement engine
    output var logic meas_start,
    output var logic meas_rht_only,
    input wire logic result_valid,
    input wire logic [15:0] gas_word,
    input wire logic [15:0] temp_word,
    input wire logic [15:0] hum_word,
    // Status and host parameter words
    output var logic asleep,
    output var logic busy,
    output var logic [15:0] param_word,
    output var logic param_valid,
    output var logic crc_err
);

    // ----------
    // Bus edge detection
    // ----------
    typedef enum {bs_idle, bs_rx, bs_rx_ack, bs_tx, bs_tx_ack} ssc_bus_t;
    typedef enum {ps_idle, ps_meas, ps_to_sleep, ps_sleep, ps_waking}
        ssc_pwr_t;

    ssc_crc_if cif ();

    ssc_crc8 u_crc (
        .ref_clk(ref_clk),
        .srst(srst),
        .cif(cif)
    );

    logic scl_q, sda_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Start and stop are data edges while the clock is high.
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
    assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;

    // ----------
    // Byte engine
    // ----------
    ssc_bus_t bs_q, bs_d;
    ssc_pwr_t ps_q, ps_d;
    logic [7:0] sh_q, sh_d, hi_q, hi_d, rxb;
    logic [3:0] bit_q, bit_d;
    logic first_q, first_d, rd_q, rd_d, ack_q, ack_d, mack_q, mack_d;
    logic cmd_q, cmd_d;
    logic [1:0] pos_q, pos_d, w_q, w_d;
    logic out_q, out_d, oe_q, oe_d;
    logic [15:0] pw_q, pw_d;
    logic pv_d, ce_d, cmd_fire, sleepy, load;
    logic [15:0] cmd_word;
    logic [15:0] res_q [3];
    logic [15:0] txw;
    logic [7:0] txb;

    assign rxb = {sh_q[6:0], sda_i};
    assign cmd_word = {hi_q, rxb};
    assign sleepy = (ps_q == ps_sleep) || (ps_q == ps_to_sleep);
    assign txw = res_q[w_q];
    // Device-returned words carry their checksum as the third byte.
    assign txb = (pos_q == POS_CRC) ? cif.crc :
                 (pos_q == POS_HI) ? txw[15:8] : txw[7:0];

    // Next state of the byte engine.
    always_comb
    begin
        bs_d = bs_q;
        sh_d = sh_q;
        hi_d = hi_q;
        bit_d = bit_q;
        first_d = first_q;
        rd_d = rd_q;
        ack_d = ack_q;
        mack_d = mack_q;
        cmd_d = cmd_q;
        pos_d = pos_q;
        w_d = w_q;
        out_d = out_q;
        oe_d = oe_q;
        pw_d = pw_q;
        pv_d = 1'b0;
        ce_d = 1'b0;
        cmd_fire = 1'b0;
        load = 1'b0;
        cif.init = 1'b0;
        cif.feed = 1'b0;
        cif.data = rxb;
        if (bus_start)
        begin
            bs_d = bs_rx;
            bit_d = 4'h0;
            first_d = 1'b1;
            cmd_d = 1'b1;
            oe_d = 1'b0;
        end
        else if (bus_stop)
        begin
            bs_d = bs_idle;
            oe_d = 1'b0;
        end
        else
        begin
            unique case (bs_q)
                bs_idle:
                begin
                    oe_d = 1'b0;
                end
                bs_rx:
                begin
                    if (scl_rise && bit_q != BITS_PER_BYTE)
                    begin
                        sh_d = rxb;
                        bit_d = bit_q + 4'h1;
                        if (bit_q == BITS_PER_BYTE - 4'h1)
                        begin
                            ack_d = ~sleepy;
                            if (first_q)
                            begin
                                first_d = 1'b0;
                                rd_d = rxb[0];
                                pos_d = POS_HI;
                                w_d = 2'h0;
                                // A sleeping device answers nothing.
                                if (rxb[7:1] != DEV_ADDR || (rxb[0] && sleepy))
                                begin
                                    bs_d = bs_idle;
                                end
                            end
                            else if (cmd_q)
                            begin
                                // Command word, high byte first.
                                if (pos_q == POS_HI)
                                begin
                                    hi_d = rxb;
                                    pos_d = POS_LO;
                                end
                                else
                                begin
                                    cmd_fire = 1'b1; // No checksum follows.
                                    cmd_d = 1'b0;
                                    pos_d = POS_HI;
                                end
                            end
                            else
                            begin
                                // Host-written data word and its checksum.
                                cif.feed = (pos_q != POS_CRC);
                                cif.init = (pos_q == POS_HI);
                                pos_d = (pos_q == POS_CRC) ? POS_HI :
                                        pos_q + 2'h1;
                                if (pos_q == POS_HI)
                                begin
                                    hi_d = rxb;
                                end
                                else if (pos_q == POS_LO)
                                begin
                                    pw_d = {hi_q, rxb};
                                end
                                else if (rxb == cif.crc)
                                begin
                                    pv_d = 1'b1;
                                end
                                else
                                begin
                                    ce_d = 1'b1;
                                    ack_d = 1'b0;
                                end
                            end
                        end
                    end
                    else if (scl_fall && bit_q == BITS_PER_BYTE)
                    begin
                        bs_d = bs_rx_ack;
                        out_d = 1'b0;
                        oe_d = ack_q;
                    end
                end
                bs_rx_ack:
                begin
                    if (scl_fall)
                    begin
                        bit_d = 4'h0;
                        oe_d = 1'b0;
                        bs_d = rd_q ? bs_tx : bs_rx;
                        load = rd_q;
                    end
                end
                bs_tx:
                begin
                    if (scl_fall)
                    begin
                        if (bit_q == BITS_PER_BYTE)
                        begin
                            bs_d = bs_tx_ack;
                            oe_d = 1'b0;
                            pos_d = (pos_q == POS_CRC) ? POS_HI :
                                    pos_q + 2'h1;
                            if (pos_q == POS_CRC)
                            begin
                                w_d = (w_q == LAST_WORD) ? 2'h0 : w_q + 2'h1;
                            end
                        end
                        else
                        begin
                            out_d = sh_q[7];
                            oe_d = ~sh_q[7];
                            sh_d = {sh_q[6:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                bs_tx_ack:
                begin
                    if (scl_rise)
                    begin
                        mack_d = ~sda_i;
                    end
                    else if (scl_fall)
                    begin
                        bs_d = mack_q ? bs_tx : bs_idle;
                        load = mack_q;
                    end
                end
            endcase
        end
        // Both ack phases launch the next outgoing byte the same way.
        if (load)
        begin
            cif.data = txb;
            cif.feed = (pos_q != POS_CRC);
            cif.init = (pos_q == POS_HI);
            sh_d = {txb[6:0], 1'b0};
            out_d = txb[7];
            oe_d = ~txb[7];
            bit_d = 4'h1;
        end
    end

    // Registers the byte engine.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bs_q <= bs_idle;
            sh_q <= 8'h00;
            hi_q <= 8'h00;
            bit_q <= 4'h0;
            first_q <= 1'b0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            mack_q <= 1'b0;
            cmd_q <= 1'b0;
            pos_q <= POS_HI;
            w_q <= 2'h0;
            out_q <= 1'b1;
            oe_q <= 1'b0;
            pw_q <= 16'h0000;
            param_valid <= 1'b0;
            crc_err <= 1'b0;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            bs_q <= bs_d;
            sh_q <= sh_d;
            hi_q <= hi_d;
            bit_q <= bit_d;
            first_q <= first_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
            mack_q <= mack_d;
            cmd_q <= cmd_d;
            pos_q <= pos_d;
            w_q <= w_d;
            out_q <= out_d;
            oe_q <= oe_d;
            pw_q <= pw_d;
            param_valid <= pv_d;
            crc_err <= ce_d;
        end
    end

    assign sda_o = out_q;
    assign sda_oe = oe_q;
    assign param_word = pw_q;

    // ----------
    // Power and measurement sequencer
    // ----------
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic rht_q, rht_d, start_d;
    logic [15:0] res_d [3];

    // Next state of the sequencer and result words.
    always_comb
    begin
        ps_d = ps_q;
        cnt_d = cnt_q;
        rht_d = rht_q;
        start_d = 1'b0;
        res_d = res_q;
        unique case (ps_q)
            ps_idle:
            begin
                if (cmd_fire && cmd_word == CMD_MEAS_FULL)
                begin
                    ps_d = ps_meas;
                    rht_d = 1'b0;
                    start_d = 1'b1;
                    cnt_d = CNT_W'(MEAS_FULL_CYCLES);
                end
                else if (cmd_fire && cmd_word == CMD_MEAS_RHT)
                begin
                    ps_d = ps_meas;
                    rht_d = 1'b1;
                    start_d = 1'b1;
                    cnt_d = CNT_W'(MEAS_RHT_CYCLES);
                end
                else if (cmd_fire && cmd_word == CMD_SLEEP)
                begin
                    ps_d = ps_to_sleep;
                    cnt_d = CNT_W'(SLEEP_CYCLES);
                end
            end
            ps_meas:
            begin
                cnt_d = cnt_q - 1'b1;
                if (result_valid)
                begin
                    res_d[0] = rht_q ? 16'h0000 : gas_word;
                    res_d[1] = temp_word;
                    res_d[2] = hum_word;
                    ps_d = ps_idle;
                end
                else if (cnt_q == '0)
                begin
                    ps_d = ps_idle;
                end
            end
            ps_to_sleep:
            begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0)
                begin
                    ps_d = ps_sleep;
                end
            end
            ps_sleep:
            begin
                // Wake is heard even though it is never acknowledged.
                if (cmd_fire && cmd_word == CMD_WAKE)
                begin
                    ps_d = ps_waking;
                    cnt_d = CNT_W'(WAKE_CYCLES);
                end
            end
            ps_waking:
            begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == '0)
                begin
                    ps_d = ps_idle;
                end
            end
        endcase
    end

    // Registers the sequencer.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ps_q <= ps_idle;
            cnt_q <= '0;
            rht_q <= 1'b0;
            res_q <= '{default: 16'h0000};
            meas_start <= 1'b0;
            meas_rht_only <= 1'b0;
            asleep <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            ps_q <= ps_d;
            cnt_q <= cnt_d;
            rht_q <= rht_d;
            res_q <= res_d;
            meas_start <= start_d;
            meas_rht_only <= rht_d;
            asleep <= (ps_d == ps_sleep);
            busy <= (ps_d != ps_idle) && (ps_d != ps_sleep);
        end
    end

endmodule // ssc_cmd_top

`default_nettype wire

// >>> test/ssc_cmd_chk.sv
// Port checker of the single-shot, sleep and checksum command block.
// Assumes it is bound to ssc_cmd_top with the same cycle parameters.
`timescale 1ns/100ps
`default_nettype none

module ssc_cmd_chk #(
    parameter int unsigned MEAS_FULL_CYCLES = 40,
    parameter int unsigned MEAS_RHT_CYCLES = 20
)
(
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_oe,
    // Sequencer and status
    input wire logic meas_start,
    input wire logic meas_rht_only,
    input wire logic result_valid,
    input wire logic asleep,
    input wire logic busy,
    input wire logic param_valid,
    input wire logic crc_err
);
    logic [31:0] run_q, run_d;
    logic full_q, full_d, meas_q, meas_d;

    // Counts busy cycles and notes which shot is in progress.
    always_comb
    begin
        run_d = busy ? run_q + 32'h1 : 32'h0;
        full_d = meas_start ? !meas_rht_only : full_q;
        meas_d = meas_start | (meas_q & busy);
    end

    // Registers the helper state.
    always_ff @(posedge ref_clk)
    begin
        run_q <= srst ? 32'h0 : run_d;
        full_q <= srst ? 1'b0 : full_d;
        meas_q <= srst ? 1'b0 : meas_d;
    end

    // Properties share one clock and the synchronous reset.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_shot; busy && !meas_start; endsequence
    sequence s_wake; busy ##1 busy; endsequence
    property p_start; meas_start |=> s_shot; endproperty
    property p_idle; meas_start |-> $past(!busy && !asleep); endproperty
    property p_result; meas_q && result_valid |-> ##[1:2] !busy; endproperty
    property p_bound;
        run_q <= (full_q ? MEAS_FULL_CYCLES : MEAS_RHT_CYCLES) + 2;
    endproperty
    property p_sleep; $rose(asleep) |-> $past(busy); endproperty
    property p_wake; $fell(asleep) |-> ##[0:1] s_wake; endproperty
    property p_nack; $fell(asleep) |-> !sda_oe [*8]; endproperty
    property p_edge; $changed(sda_oe) |-> !scl_i; endproperty
    property p_crc; param_valid |-> !crc_err ##1 !param_valid; endproperty

    a_start: assert property (p_start)
        else $error("shot pulse too long or not busy");
    a_idle: assert property (p_idle)
        else $error("shot started while not idle");
    a_result: assert property (p_result)
        else $error("busy stayed after result");
    a_bound: assert property (p_bound)
        else $error("busy longer than allowed");
    a_sleep: assert property (p_sleep)
        else $error("asleep without entry period");
    a_wake: assert property (p_wake)
        else $error("no busy period after wake");
    a_nack: assert property (p_nack)
        else $error("wake transfer acknowledged");
    a_edge: assert property (p_edge)
        else $error("data driver moved while scl high");
    a_crc: assert property (p_crc)
        else $error("checksum flags clash");
endmodule // ssc_cmd_chk

bind ssc_cmd_top ssc_cmd_chk #(.MEAS_FULL_CYCLES(MEAS_FULL_CYCLES),
    .MEAS_RHT_CYCLES(MEAS_RHT_CYCLES)) ssc_cmd_chk_i (.ref_clk, .srst,
    .scl_i, .sda_oe, .meas_start, .meas_rht_only, .result_valid, .asleep,
    .busy, .param_valid, .crc_err);

`default_nettype wire

// >>> test/ssc_host_bfm.sv
// Two-wire bus master standing in for the host controller.
// Assumes a pull-up on the data wire and scl sampled on ref_clk.
`timescale 1ns/100ps
`default_nettype none

module ssc_host_bfm (
    // Clock
    input wire logic ref_clk,
    // Bus lines; sda_drv low pulls the wire down
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda
);
    // Bus idle from time zero.
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Half a bit time; every change lands just after an edge.
    task automatic half();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // One bit: data set while scl is low, wire read at the end of high.
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask

    // Start moves data while scl is high; stop pulls data low while scl is low, then releases it while scl is high.
    task automatic start_c();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop_c();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask

    // Byte out, most significant bit first, then the device's answer.
    task automatic wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    // Byte in; a low mack ends the read.
    task automatic rd(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(!mack, r);
    endtask
endmodule // ssc_host_bfm

`default_nettype wire

// >>> test/ssc_cmd_top_tb.sv
// Self-checking bench of the single-shot, sleep and checksum block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module ssc_cmd_top_tb
    import ssc_pkg::*;
();
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic result_valid = 1'b0;
    logic cur_rht = 1'b0;
    logic scl, sda_drv, sda_o, sda_oe, meas_start, meas_rht_only;
    logic asleep, busy, param_valid, crc_err;
    logic [15:0] gas_word = 16'h0, temp_word = 16'h0, hum_word = 16'h0;
    logic [15:0] param_word, w;
    logic [15:0] ex[3];
    logic [31:0] seed = 32'h2b81;
    logic q_rht[$];
    logic [16:0] q_par[$];
    int errors = 0;
    int samples_checked = 0;
    wire logic sda = sda_drv & (sda_o | ~sda_oe);

    // Clock of 4 ns.
    always #2 ref_clk = ~ref_clk;

    ssc_cmd_top #(.MEAS_FULL_CYCLES(40), .MEAS_RHT_CYCLES(20),
        .SLEEP_CYCLES(10), .WAKE_CYCLES(10)) ssc_cmd_top_i (.ref_clk,
        .srst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .meas_start,
        .meas_rht_only, .result_valid, .gas_word, .temp_word, .hum_word,
        .asleep, .busy, .param_word, .param_valid, .crc_err);
    ssc_host_bfm host_i (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv),
        .sda(sda));

    // Random source and checksum of one word.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return c ^ CRC_XOR_OUT;
    endfunction

    // Comparisons and the verdict.
    task automatic chk_w(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({16'h0, got}, {16'h0, exp});
    endtask
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Write transfer: address, command, optional word and checksum.
    task automatic wcmd(input logic [6:0] ad, input logic [15:0] cmd,
        input logic [5:0] ea, input int n, input logic [15:0] wd);
        logic a;
        logic [7:0] b[6];
        b = '{{ad, 1'b0}, cmd[15:8], cmd[7:0], wd[15:8], wd[7:0],
            crc8(wd) ^ {7'h0, !ea[0]}};
        host_i.start_c();
        for (int i = 0; i < n; i++)
        begin
            host_i.wr(b[i], a);
            chk_b(a, ea[5 - i]);
        end
        host_i.stop_c();
    endtask

    // Reads the three result words with their checksums.
    task automatic rd3();
        logic a;
        logic [7:0] h, l, c;
        host_i.start_c();
        host_i.wr({DEV_ADDR_DEF, 1'b1}, a);
        chk_b(a, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            host_i.rd(1'b1, h);
            host_i.rd(1'b1, l);
            host_i.rd(i < 2, c);
            chk_w({1'b0, h, l}, {1'b0, ex[i]});
            chk_w({9'h0, c}, {9'h0, crc8(ex[i])});
        end
        host_i.stop_c();
    endtask

    // Waits, bounded, until the block is idle.
    task automatic wait_idle();
        for (int n = 0; n < 100 && busy !== 1'b0; n++)
            @(posedge ref_clk);
        chk_b(busy, 1'b0);
    endtask

    // Takes the oldest note off its queue whenever the block reports.
    always @(posedge ref_clk)
    begin
        if (meas_start === 1'b1)
            chk_b(meas_rht_only,
                q_rht.size() > 0 ? q_rht.pop_front() : 1'bx);
        if (param_valid === 1'b1 || crc_err === 1'b1)
            chk_w({crc_err, param_word},
                q_par.size() > 0 ? q_par.pop_front() : 17'hx);
    end

    // Measurement engine answering each shot after a random wait.
    always @(posedge ref_clk)
        if (meas_start === 1'b1)
        begin
            repeat (3 + rnd() % 8) @(posedge ref_clk);
            #1;
            gas_word = 16'(rnd());
            temp_word = 16'(rnd());
            hum_word = 16'(rnd());
            ex = '{cur_rht ? 16'h0 : gas_word, temp_word, hum_word};
            result_valid = 1'b1;
            @(posedge ref_clk);
            #1;
            result_valid = 1'b0;
        end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        wcmd(DEV_ADDR_DEF ^ 7'h01, CMD_MEAS_FULL, 6'h00, 1, 16'h0);
        for (int k = 0; k < 2; k++)
        begin
            cur_rht = k[0];
            q_rht.push_back(cur_rht);
            wcmd(DEV_ADDR_DEF, k ? CMD_MEAS_RHT : CMD_MEAS_FULL, 6'h38, 3,
                16'h0);
            wait_idle();
            rd3();
        end
        for (int k = 0; k < 2; k++)
        begin
            w = 16'(rnd());
            q_par.push_back({k[0], w});
            wcmd(DEV_ADDR_DEF, 16'h219e, {5'h1f, !k[0]}, 6, w);
        end
        wcmd(DEV_ADDR_DEF, CMD_SLEEP, 6'h38, 3, 16'h0);
        repeat (12) @(posedge ref_clk);
        chk_b(asleep, 1'b1);
        wcmd(DEV_ADDR_DEF, CMD_MEAS_FULL, 6'h00, 3, 16'h0);
        wcmd(DEV_ADDR_DEF, CMD_WAKE, 6'h00, 3, 16'h0);
        chk_b(asleep, 1'b0);
        wait_idle();
        rd3();
        end_sim();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        end_sim();
    end
endmodule // ssc_cmd_top_tb

`default_nettype wire
